// file: rtl/bod_decoder.sv
`timescale 1ns/10ps
module bod_decoder
    import bod_pkg::*;
(
    // clock and reset
    input  wire logic                  CLK_IN,
    input  wire logic                  RSTN_IN,
    // program memory side
    input  wire logic [INSN_W-1:0]     INSN_IN,
    input  wire logic                  INSN_VALID_IN,
    output logic                       FETCH_OUT,
    // datapath operands
    input  wire logic [DATA_W-1:0]     ACC_IN,
    input  wire logic [DATA_W-1:0]     FILE_DATA_IN,
    input  wire logic                  CARRY_IN,
    // decoded fields
    output logic [FADDR_W-1:0]         FADDR_OUT,
    output logic [2:0]                 BIT_SEL_OUT,
    output logic [LIT11_W-1:0]         LITERAL_OUT,
    output logic                       LIT_LONG_OUT,
    // results, stored at the end of the cycle
    output logic [DATA_W-1:0]          RESULT_OUT,
    output logic                       ACC_WE_OUT,
    output logic                       FILE_WE_OUT,
    output logic                       CARRY_OUT,
    output logic                       DC_OUT,
    output logic                       ZERO_OUT,
    output logic                       CARRY_WE_OUT,
    output logic                       DC_WE_OUT,
    output logic                       ZERO_WE_OUT,
    // timing
    output logic                       PHASE_Q1_OUT,
    output logic                       NOP_CYCLE_OUT,
    output logic                       SKIP_OUT
);

    bod_phase_t   phase_reg;
    bod_phase_t   phase_next;
    logic         end_of_cycle;
    logic         flush_reg;
    bod_fields_t  fld;
    bod_result_t  res;
    bod_result_t  res_reg;
    logic         skip_now;
    logic         flush_next;
    logic [FADDR_W-1:0]  faddr_reg;
    logic [2:0]          bit_reg;
    logic [LIT11_W-1:0]  lit_reg;
    logic                lit_long_reg;
    logic                skip_reg;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == '0; // RULE14
    endfunction

    // four oscillator phases per instruction cycle, gray ordered
    always_comb
    begin
        unique case (phase_reg)
            PH_Q1: phase_next = PH_Q2;
            PH_Q2: phase_next = PH_Q3;
            PH_Q3: phase_next = PH_Q4;
            PH_Q4: phase_next = PH_Q1;
        endcase
    end
    assign end_of_cycle = (phase_reg == PH_Q4); // RULE8

    // field split; don't-care bits are simply never looked at
    assign fld.valid     = INSN_VALID_IN;
    assign fld.is_byte   = (INSN_IN[INSN_W-1:CLS_LSB] == CLS_BYTE); // RULE9
    assign fld.op        = INSN_IN[CLS_LSB-1:OP_LSB]; // RULE1
    assign fld.dest_file = INSN_IN[DEST_BIT]; // RULE2
    assign fld.faddr     = INSN_IN[FADDR_LSB +: FADDR_W]; // RULE3
    assign fld.bit_sel   = INSN_IN[BIT_LSB +: 3]; // RULE4
    assign fld.literal   = (INSN_IN[INSN_W-1:CLS_LSB] == CLS_JUMP)
                         ? INSN_IN[LIT11_W-1:0]
                         : {3'h0, INSN_IN[LIT8_W-1:0]}; // RULE5
    assign fld.lit_long  = (INSN_IN[INSN_W-1:CLS_LSB] == CLS_JUMP); // RULE5 RULE6

    // byte-oriented arithmetic
    logic [DATA_W:0]   add_sum;
    logic [DATA_W:0]   sub_dif;
    logic [NIB_W:0]    add_nib;
    logic [NIB_W:0]    sub_nib;
    logic [DATA_W-1:0] inc_val;
    logic [DATA_W-1:0] dec_val;
    assign add_sum = {1'b0, FILE_DATA_IN} + {1'b0, ACC_IN};
    assign sub_dif = {1'b0, FILE_DATA_IN} + {1'b0, ~ACC_IN} + 9'h001;
    assign add_nib = {1'b0, FILE_DATA_IN[NIB_W-1:0]} + {1'b0, ACC_IN[NIB_W-1:0]};
    assign sub_nib = {1'b0, FILE_DATA_IN[NIB_W-1:0]} + {1'b0, ~ACC_IN[NIB_W-1:0]} + 5'h01;
    assign inc_val = FILE_DATA_IN + 8'h01;
    assign dec_val = FILE_DATA_IN - 8'h01;

    // a flushed cycle and non-byte words leave the datapath alone
    logic byte_go;
    assign byte_go = fld.valid && fld.is_byte && !flush_reg;

    always_comb
    begin
        res          = '0;
        skip_now     = 1'b0;
        res.acc_we   = byte_go && (fld.dest_file == DEST_ACC); // RULE2
        res.file_we  = byte_go && (fld.dest_file == DEST_FILE); // RULE2
        unique case (bod_byte_op_t'(fld.op))
            OP_ADD:
            begin
                res.result   = add_sum[DATA_W-1:0];
                res.flags.c  = add_sum[DATA_W];
                res.flags.dc = add_nib[NIB_W];
                res.c_we     = byte_go; // RULE10
                res.dc_we    = byte_go;
                res.z_we     = byte_go;
            end
            OP_SUB:
            begin
                res.result   = sub_dif[DATA_W-1:0];
                res.flags.c  = sub_dif[DATA_W];
                res.flags.dc = sub_nib[NIB_W];
                res.c_we     = byte_go; // RULE10
                res.dc_we    = byte_go;
                res.z_we     = byte_go;
            end
            OP_AND:
            begin
                res.result = FILE_DATA_IN & ACC_IN;
                res.z_we   = byte_go; // RULE10
            end
            OP_OR:
            begin
                res.result = FILE_DATA_IN | ACC_IN;
                res.z_we   = byte_go; // RULE10
            end
            OP_XOR:
            begin
                res.result = FILE_DATA_IN ^ ACC_IN;
                res.z_we   = byte_go;
            end
            OP_COMPLEMENT:
            begin
                res.result = ~FILE_DATA_IN;
                res.z_we   = byte_go; // RULE10
            end
            OP_MOVE:
            begin
                res.result = FILE_DATA_IN;
                res.z_we   = byte_go; // RULE10
            end
            OP_INC:
            begin
                res.result = inc_val;
                res.z_we   = byte_go; // RULE10
            end
            OP_DEC:
            begin
                res.result = dec_val;
                res.z_we   = byte_go; // RULE10
            end
            OP_ROT_LEFT:
            begin
                res.result  = {FILE_DATA_IN[DATA_W-2:0], CARRY_IN};
                res.flags.c = FILE_DATA_IN[DATA_W-1];
                res.c_we    = byte_go; // RULE11
            end
            OP_ROT_RIGHT:
            begin
                res.result  = {CARRY_IN, FILE_DATA_IN[DATA_W-1:1]};
                res.flags.c = FILE_DATA_IN[0];
                res.c_we    = byte_go; // RULE11
            end
            OP_DEC_SKIP:
            begin
                res.result = dec_val;
                skip_now   = byte_go && is_zero(dec_val); // RULE12
            end
            OP_INC_SKIP:
            begin
                res.result = inc_val;
                skip_now   = byte_go && is_zero(inc_val); // RULE12
            end
            OP_SWAP:
            begin
                res.result = {FILE_DATA_IN[NIB_W-1:0], FILE_DATA_IN[DATA_W-1:NIB_W]};
            end
            OP_CLEAR:
            begin
                // d bit picks acc or file, both cleared to zero
                res.result = '0;
                res.z_we   = byte_go;
            end
            OP_MOVE_TO_FILE:
            begin
                // only the d=1 form writes; d=0 is the no-operation family
                res.result = ACC_IN;
                res.acc_we = 1'b0;
            end
        endcase
        res.flags.z = is_zero(res.result); // RULE14
    end

    // a taken skip or a jump turns the following cycle into a nop
    assign flush_next = skip_now
                     || (fld.valid && !flush_reg && fld.lit_long); // RULE7

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            phase_reg <= PH_Q1;
        else
            phase_reg <= phase_next;
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            res_reg      <= '0;
            flush_reg    <= 1'b0;
            skip_reg     <= 1'b0;
            faddr_reg    <= '0;
            bit_reg      <= '0;
            lit_reg      <= '0;
            lit_long_reg <= 1'b0;
        end
        else if (end_of_cycle)
        begin
            res_reg      <= res;
            flush_reg    <= flush_next; // RULE7
            skip_reg     <= skip_now;
            faddr_reg    <= fld.faddr;
            bit_reg      <= fld.bit_sel;
            lit_reg      <= fld.literal;
            lit_long_reg <= fld.lit_long;
        end
        else
        begin
            // strobes last one clock so each result is stored exactly once
            res_reg.acc_we  <= 1'b0;
            res_reg.file_we <= 1'b0;
            res_reg.c_we    <= 1'b0;
            res_reg.dc_we   <= 1'b0;
            res_reg.z_we    <= 1'b0;
        end
    end

    assign FETCH_OUT     = end_of_cycle;
    assign PHASE_Q1_OUT  = (phase_reg == PH_Q1);
    assign NOP_CYCLE_OUT = flush_reg;
    assign SKIP_OUT      = skip_reg;
    assign FADDR_OUT     = faddr_reg;
    assign BIT_SEL_OUT   = bit_reg;
    assign LITERAL_OUT   = lit_reg;
    assign LIT_LONG_OUT  = lit_long_reg;
    assign RESULT_OUT    = res_reg.result;
    assign ACC_WE_OUT    = res_reg.acc_we;
    assign FILE_WE_OUT   = res_reg.file_we;
    assign CARRY_OUT     = res_reg.flags.c;
    assign DC_OUT        = res_reg.flags.dc;
    assign ZERO_OUT      = res_reg.flags.z;
    assign CARRY_WE_OUT  = res_reg.c_we;
    assign DC_WE_OUT     = res_reg.dc_we;
    assign ZERO_WE_OUT   = res_reg.z_we;

endmodule

// file: rtl/bod_pkg.sv
// What this block does
// RULE1 - each instruction is one fourteen-bit word: opcode plus operand fields
// RULE2 - destination bit 0 writes the working register, 1 writes the file register
// RULE3 - file address is a seven-bit field covering locations 0x00 to 0x7f
// RULE4 - bit-oriented ops: three-bit bit select inside the addressed eight-bit register
// RULE5 - literal ops carry an eight-bit or an eleven-bit literal by instruction
// RULE6 - don't-care bits are ignored; either value decodes the same instruction
// RULE7 - one instruction cycle, two when a skip is taken or pc changes; second is nop
// RULE8 - one instruction cycle spans four oscillator periods
// RULE9 - byte ops have top bits 00, then four op bits, destination bit, file address
// RULE10 - byte op codes; add and subtract set carry, digit carry, zero; others zero only; swap and move-to-file here write no flags
// RULE11 - rotate left 1101 and right 1100 go through carry and change only carry
// RULE12 - decrement/increment-and-skip 1011/1111 skip on zero result, flags untouched
// RULE13 - software avoids legacy option-load and tristate-load instructions
// RULE14 - zero flag set on an all-zero eight-bit result, cleared otherwise
package bod_pkg;
    localparam int INSN_W    = 14;
    localparam int FADDR_W   = 7;
    localparam int DATA_W    = 8;
    localparam int PHASES    = 4;
    localparam int FADDR_LSB = 0;
    localparam int DEST_BIT  = 7;
    localparam int OP_LSB    = 8;
    localparam int CLS_LSB   = 12;
    localparam int BIT_LSB   = 7;
    localparam int LIT8_W    = 8;
    localparam int LIT11_W   = 11;
    localparam int NIB_W     = 4;

    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT  = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT  = 2'h3;

    typedef enum logic [3:0] {
        OP_MOVE_TO_FILE  = 4'h0,
        OP_CLEAR         = 4'h1,
        OP_SUB           = 4'h2,
        OP_DEC           = 4'h3,
        OP_OR            = 4'h4,
        OP_AND           = 4'h5,
        OP_XOR           = 4'h6,
        OP_ADD           = 4'h7,
        OP_MOVE          = 4'h8,
        OP_COMPLEMENT    = 4'h9,
        OP_INC           = 4'ha,
        OP_DEC_SKIP      = 4'hb,
        OP_ROT_RIGHT     = 4'hc,
        OP_ROT_LEFT      = 4'hd,
        OP_SWAP          = 4'he,
        OP_INC_SKIP      = 4'hf
    } bod_byte_op_t;

    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } bod_phase_t;

    typedef struct packed {
        logic                     valid;
        logic                     is_byte;
        logic [3:0]               op;
        logic                     dest_file;
        logic [FADDR_W-1:0]       faddr;
        logic [2:0]               bit_sel;
        logic [LIT11_W-1:0]       literal;
        logic                     lit_long;
    } bod_fields_t;

    typedef struct packed {
        logic              c;
        logic              dc;
        logic              z;
    } bod_flags_t;

    typedef struct packed {
        logic              acc_we;
        logic              file_we;
        logic [DATA_W-1:0] result;
        logic              c_we;
        logic              dc_we;
        logic              z_we;
        bod_flags_t        flags;
    } bod_result_t;
endpackage

// file: bench/bod_decoder_sva.sv
`timescale 1ns/10ps
module bod_decoder_sva
    import bod_pkg::*;
(
    // watched ports
    input  wire logic               CLK_IN,
    input  wire logic               RSTN_IN,
    input  wire logic [INSN_W-1:0]  INSN_IN,
    input  wire logic               INSN_VALID_IN,
    input  wire logic               FETCH_OUT,
    input  wire logic [FADDR_W-1:0] FADDR_OUT,
    input  wire logic [LIT11_W-1:0] LITERAL_OUT,
    input  wire logic               LIT_LONG_OUT,
    input  wire logic [DATA_W-1:0]  RESULT_OUT,
    input  wire logic               ACC_WE_OUT,
    input  wire logic               FILE_WE_OUT,
    input  wire logic               ZERO_OUT,
    input  wire logic               CARRY_WE_OUT,
    input  wire logic               DC_WE_OUT,
    input  wire logic               ZERO_WE_OUT,
    input  wire logic               PHASE_Q1_OUT,
    input  wire logic               NOP_CYCLE_OUT,
    input  wire logic               SKIP_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    a_fetch_period: assert property (FETCH_OUT |=> !FETCH_OUT [*3] ##1 FETCH_OUT)
        else $error("fetch strobe not every fourth clock");
    a_strobe_q1: assert property ((ACC_WE_OUT || FILE_WE_OUT || ZERO_WE_OUT) |->
        PHASE_Q1_OUT && $past(FETCH_OUT) ##1 !(ACC_WE_OUT || FILE_WE_OUT))
        else $error("write strobe outside first clock of cycle");
    a_dest_select: assert property (FILE_WE_OUT |-> $past(INSN_IN[7])
        && $past(INSN_IN[13:12]) == CLS_BYTE && !ACC_WE_OUT)
        else $error("file write without destination bit");
    a_faddr_field: assert property (FILE_WE_OUT |-> FADDR_OUT == $past(INSN_IN[6:0]))
        else $error("file address field wrong");
    a_nop_no_write: assert property ((NOP_CYCLE_OUT && FETCH_OUT) |=>
        !(ACC_WE_OUT || FILE_WE_OUT || SKIP_OUT))
        else $error("flushed word had an effect");
    a_skip_flush: assert property ($rose(SKIP_OUT) |-> NOP_CYCLE_OUT [*4])
        else $error("taken skip not followed by a nop cycle");
    a_skip_no_flags: assert property (SKIP_OUT |->
        !(CARRY_WE_OUT || DC_WE_OUT || ZERO_WE_OUT))
        else $error("skip op touched flags");
    a_zero_flag: assert property (ZERO_WE_OUT |-> ZERO_OUT == (RESULT_OUT == 8'h00))
        else $error("zero flag disagrees with result");
    a_arith_flags: assert property (DC_WE_OUT |-> CARRY_WE_OUT && ZERO_WE_OUT)
        else $error("digit carry written alone");
    a_rotate_carry: assert property ((CARRY_WE_OUT && !DC_WE_OUT) |->
        !ZERO_WE_OUT && $past(INSN_IN[11:9]) == 3'h6)
        else $error("carry-only write not from a rotate");
    a_lit_long: assert property ((PHASE_Q1_OUT && $past(FETCH_OUT) && $past(INSN_VALID_IN)
        && !$past(NOP_CYCLE_OUT) && LIT_LONG_OUT) |-> LITERAL_OUT == $past(INSN_IN[10:0]))
        else $error("long literal field wrong");
endmodule

bind bod_decoder bod_decoder_sva u_sva (.CLK_IN, .RSTN_IN, .INSN_IN, .INSN_VALID_IN,
    .FETCH_OUT, .FADDR_OUT, .LITERAL_OUT, .LIT_LONG_OUT, .RESULT_OUT, .ACC_WE_OUT,
    .FILE_WE_OUT, .ZERO_OUT, .CARRY_WE_OUT, .DC_WE_OUT, .ZERO_WE_OUT, .PHASE_Q1_OUT,
    .NOP_CYCLE_OUT, .SKIP_OUT);

// file: bench/bod_prog_mem.sv
`timescale 1ns/10ps
module bod_prog_mem
    import bod_pkg::*;
(
    // clock, reset and fetch strobe
    input  wire logic          CLK_IN,
    input  wire logic          RSTN_IN,
    input  wire logic          FETCH_IN,
    // instruction word
    output logic [INSN_W-1:0]  INSN_OUT = '0,
    output logic               INSN_VALID_OUT = 1'b0
);
    logic [INSN_W:0] prog [0:127];
    int              ptr = 0;
    logic            step;
    logic            clr;
    always @(posedge CLK_IN)
    begin
        step = RSTN_IN && FETCH_IN;
        clr = !RSTN_IN;
        #1;
        ptr = clr ? 0 : ptr + int'(step);
        INSN_VALID_OUT = prog[ptr][INSN_W];
        // an empty slot toggles so no stale word can pass for a real one
        INSN_OUT = INSN_VALID_OUT ? prog[ptr][INSN_W-1:0] : ~INSN_OUT;
    end
endmodule

// file: bench/tb_byte_op_instruction_decoder.sv
`timescale 1ns/10ps
module tb_byte_op_instruction_decoder;
    import bod_pkg::*;
    localparam int N_ALL = 64;
    localparam int FLG [16] = '{0, 1, 7, 1, 1, 1, 1, 7, 1, 1, 1, 0, 4, 4, 0, 0};
    logic clk = 1'b0, rstn = 1'b0, cin = 1'b0;
    logic valid, fetch, lit_long, awe, fwe, c, dc, z, cwe, dcwe, zwe, q1, nop, skip;
    logic [INSN_W-1:0]  insn;
    logic [DATA_W-1:0]  acc = '0, fdat = '0, res;
    logic [FADDR_W-1:0] faddr;
    logic [2:0]         bsel;
    logic [LIT11_W-1:0] lit;
    logic [7:0]         op_a [N_ALL], op_f [N_ALL];
    logic               op_c [N_ALL];
    int n_mismatch = 0, n_compared = 0, n_put = 0, e_nop = 0;

    always #50 clk = ~clk;
    bod_decoder uut (.CLK_IN(clk), .RSTN_IN(rstn), .INSN_IN(insn), .INSN_VALID_IN(valid),
        .FETCH_OUT(fetch), .ACC_IN(acc), .FILE_DATA_IN(fdat), .CARRY_IN(cin), .FADDR_OUT(faddr),
        .BIT_SEL_OUT(bsel), .LITERAL_OUT(lit), .LIT_LONG_OUT(lit_long), .RESULT_OUT(res),
        .ACC_WE_OUT(awe), .FILE_WE_OUT(fwe), .CARRY_OUT(c), .DC_OUT(dc), .ZERO_OUT(z),
        .CARRY_WE_OUT(cwe), .DC_WE_OUT(dcwe), .ZERO_WE_OUT(zwe), .PHASE_Q1_OUT(q1),
        .NOP_CYCLE_OUT(nop), .SKIP_OUT(skip));
    bod_prog_mem u_mem (.CLK_IN(clk), .RSTN_IN(rstn), .FETCH_IN(fetch), .INSN_OUT(insn),
        .INSN_VALID_OUT(valid));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic put(input logic [14:0] e, input logic [7:0] a, f, input logic ci);
        u_mem.prog[n_put] = e;
        op_a[n_put] = a;
        op_f[n_put] = f;
        op_c[n_put] = ci;
        n_put++;
    endtask

    task automatic check_word(input int i);
        logic [14:0] e;
        int w, cl, op, d, a, f, r, we, fl, sk, ecy, edc, nx;
        e = u_mem.prog[i];
        w = e[13:0];
        cl = w >> 12;
        op = (w >> 8) & 15;
        d = (w >> 7) & 1;
        a = op_a[i];
        f = op_f[i];
        we = (e_nop == 0 && e[14] && cl == 0);
        case (op)
            0: r = a;
            1: r = 0;
            2: r = f - a;
            3, 11: r = f - 1;
            4: r = a | f;
            5: r = a & f;
            6: r = a ^ f;
            7: r = a + f;
            8: r = f;
            9: r = ~f;
            10, 15: r = f + 1;
            12: r = (op_c[i] << 7) | (f >> 1);
            13: r = (f << 1) | op_c[i];
            default: r = (f << 4) | (f >> 4);
        endcase
        ecy = op == 2 ? f >= a : op == 7 ? r > 255 : op == 12 ? f & 1 : f >> 7;
        edc = op == 2 ? (f & 15) >= (a & 15) : (a & 15) + (f & 15) > 15;
        r = r & 255;
        fl = we ? FLG[op] : 0;
        if (op == 0 && d == 0)
            we = 0;
        sk = we && (op == 11 || op == 15) && r == 0;
        nx = sk || (e_nop == 0 && e[14] && cl == 2);
        chk("acc_we", awe, we & !d);
        chk("file_we", fwe, we & d);
        chk("flag_we", {cwe, dcwe, zwe}, fl);
        if (we) chk("result", res, r);
        if (fl & 1) chk("zero", z, r == 0);
        if (fl & 4) chk("carry", c, ecy);
        if (fl & 2) chk("digit_carry", dc, edc);
        chk("skip", skip, sk);
        chk("nop_cycle", nop, nx);
        if (e_nop == 0 && e[14])
        begin
            chk("faddr", faddr, w & 127);
            chk("bit_sel", bsel, (w >> 7) & 7);
            chk("lit_long", lit_long, cl == 2);
            chk("literal", lit, cl == 2 ? w & 2047 : w & 255);
        end
        e_nop = nx;
    endtask

    initial
    begin
        logic [13:0] w;
        void'($urandom(52019));
        put(15'h4791, 8'h0f, 8'hf1, 1'b0);
        put(15'h4211, 8'h01, 8'h01, 1'b0);
        put(15'h4291, 8'h02, 8'h01, 1'b0);
        put(15'h4b91, 8'h00, 8'h01, 1'b0);
        put(15'h4791, 8'h11, 8'h22, 1'b0);
        put(15'h4f11, 8'h00, 8'hff, 1'b0);
        put(15'h4a11, 8'h00, 8'h05, 1'b0);
        put(15'h4d91, 8'h00, 8'h80, 1'b1);
        put(15'h4c11, 8'h00, 8'h01, 1'b0);
        put(15'h6abc, 8'h00, 8'h00, 1'b0);
        put(15'h4791, 8'h33, 8'h44, 1'b0);
        put(15'h5395, 8'h00, 8'h00, 1'b0);
        put(15'h7eff, 8'h00, 8'h00, 1'b0);
        put(15'h417f, 8'h9a, 8'h77, 1'b1);
        put(15'h0791, 8'h01, 8'h02, 1'b0);
        put(15'h40aa, 8'h5a, 8'h00, 1'b0);
        while (n_put < N_ALL)
        begin
            w = 14'($urandom);
            // legacy option and tristate loads are kept out of the program
            if (w[13:3] == 11'h00c) w = 14'h0000;
            put({1'b1, w}, 8'($urandom), 8'($urandom), 1'($urandom));
        end
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        for (int i = 0; i < N_ALL; i++)
        begin
            acc = op_a[i];
            fdat = op_f[i];
            cin = op_c[i];
            repeat (3) @(posedge clk);
            #1 chk("fetch", fetch, 1'b1);
            @(posedge clk);
            #1 chk("phase_q1", q1, 1'b1);
            check_word(i);
        end
        report_and_stop();
    end

    initial
    begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
